// ---- hdl/iad_clock_cost.v ----
// clock cost lookup for a decoded arithmetic operation
`timescale 1ns/1ps
`default_nettype none
`include "iad_regs.vh"
module iad_clock_cost (
   input  wire [3:0] opClass,
   input  wire       isMem,
   input  wire       isWord,
   input  wire       isAccImm,
   input  wire       isImmGrp,
   input  wire       isShortReg,
   input  wire       narrowBus,
   output reg  [5:0] minClk,
   output reg  [5:0] maxClk
);
   reg [5:0] base;
   reg       narrowApplies;
   always @* begin
      base = `IAD_CLK_REG3;
      narrowApplies = 1'b0;
      maxClk = 6'h00;
      case (opClass)
         `IAD_OPC_PREFIX: base = `IAD_CLK_PREFIX;
         `IAD_OPC_UAD:    base = `IAD_CLK_UAD;
         `IAD_OPC_UAS:    base = `IAD_CLK_UAS;
         `IAD_OPC_PAD,
         `IAD_OPC_PAS:    base = `IAD_CLK_PADJ;
         `IAD_OPC_INC,
         `IAD_OPC_DEC: begin
            if (isShortReg)
               base = `IAD_CLK_REG3;
            else
               base = isMem ? `IAD_CLK_MEM15 : `IAD_CLK_REG3;
            narrowApplies = isMem;
         end
         `IAD_OPC_UPROD: begin
            case ({isMem, isWord})
               2'b00:   base = `IAD_MUL_RB_MIN;
               2'b01:   base = `IAD_MUL_RW_MIN;
               2'b10:   base = `IAD_MUL_MB_MIN;
               default: base = `IAD_MUL_MW_MIN;
            endcase
            narrowApplies = isMem;
         end
         `IAD_OPC_NONE: base = 6'h00;
         default: begin
            if (isAccImm)
               base = isWord ? `IAD_CLK_ACC16 : `IAD_CLK_REG3;
            else if (isImmGrp && opClass != `IAD_OPC_CMP)
               base = isMem ? `IAD_CLK_MEM16 : `IAD_CLK_IMMREG;
            else
               base = isMem ? `IAD_CLK_MEM10 : `IAD_CLK_REG3;
            narrowApplies = isMem;
         end
      endcase
      minClk = base;
      if (narrowBus && narrowApplies && isWord)
         minClk = base + `IAD_NARROW_ADD;
      maxClk = minClk;
      if (opClass == `IAD_OPC_UPROD)
         maxClk = minClk + `IAD_MUL_SPAN;
   end
endmodule
`default_nettype wire

// ---- hdl/iad_opcode_decoder.v ----
// arithmetic opcode and segment prefix decoder
`timescale 1ns/1ps
`default_nettype none
`include "iad_regs.vh"
module iad_opcode_decoder (
   input  wire       clk,
   input  wire       rst,
   input  wire       narrowBus,
   input  wire       byteValid,
   input  wire [7:0] byteData,
   output wire       byteReady,
   output reg  [3:0] opClass_ff,
   output reg        wordOp_ff,
   output reg        regIsDest_ff,
   output reg        signExtImm_ff,
   output reg        memOperand_ff,
   output reg  [2:0] regField_ff,
   output reg  [2:0] rmField_ff,
   output reg  [1:0] segSel_ff,
   output reg        segOverride_ff,
   output reg  [5:0] minClocks_ff,
   output reg  [5:0] maxClocks_ff,
   output reg        decodeValid_ff
);
   ////////////////////////////////////////////////////////////////////
   // decoder states
   localparam ST_OP    = 1'b0;
   localparam ST_MODRM = 1'b1;

   reg       state_ff;
   reg [7:0] opByte_ff;
   reg       nxt_state;
   reg [3:0] nxt_class;
   reg       nxt_acc;
   reg       nxt_grp;
   reg       nxt_short;
   reg       nxt_valid;
   reg       nxt_mem;
   reg [3:0] cls;
   wire [5:0] costMin;
   wire [5:0] costMax;
   wire       curWord;

   // the decoder never stalls the queue
   assign byteReady = 1'b1;

   ////////////////////////////////////////////////////////////////////
   // first-byte classification
   function [3:0] first_class;
      input [7:0] b;
      begin
         casez (b)
            8'b0000_00?? : first_class = `IAD_OPC_ADD;
            8'b0000_010? : first_class = `IAD_OPC_ADD;
            8'b0001_00?? : first_class = `IAD_OPC_ADC;
            8'b0001_010? : first_class = `IAD_OPC_ADC;
            8'b0010_10?? : first_class = `IAD_OPC_SUB;
            8'b0010_110? : first_class = `IAD_OPC_SUB;
            8'b0001_10?? : first_class = `IAD_OPC_SBB;
            8'b0001_110? : first_class = `IAD_OPC_SBB;
            8'b0011_10?? : first_class = `IAD_OPC_CMP;
            8'b0011_110? : first_class = `IAD_OPC_CMP;
            8'b0100_0??? : first_class = `IAD_OPC_INC;
            8'b0100_1??? : first_class = `IAD_OPC_DEC;
            `IAD_OP_UADJ_SUM : first_class = `IAD_OPC_UAD;
            `IAD_OP_UADJ_DIF : first_class = `IAD_OPC_UAS;
            `IAD_OP_PADJ_SUM : first_class = `IAD_OPC_PAD;
            `IAD_OP_PADJ_DIF : first_class = `IAD_OPC_PAS;
            `IAD_PFX_CODE, `IAD_PFX_STACK,
            `IAD_PFX_DATA, `IAD_PFX_EXTRA : first_class = `IAD_OPC_PREFIX;
            default : first_class = `IAD_OPC_NONE;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // second-byte classification of group opcodes
   function [3:0] group_class;
      input [7:0] op;
      input [2:0] f;
      begin
         group_class = `IAD_OPC_NONE;
         if (op[7:2] == 6'b100000) begin
            case (f)
               3'b000:  group_class = `IAD_OPC_ADD;
               3'b010:  group_class = `IAD_OPC_ADC;
               3'b101:  group_class = `IAD_OPC_SUB;
               3'b011:  group_class = `IAD_OPC_SBB;
               3'b111:  group_class = `IAD_OPC_CMP;
               default: group_class = `IAD_OPC_NONE;
            endcase
         end else if (op[7:1] == 7'b1111111) begin
            if (f == 3'b000) group_class = `IAD_OPC_INC;
            if (f == 3'b001) group_class = `IAD_OPC_DEC;
         end else if (op[7:1] == 7'b1111011) begin
            if (f == 3'b011) group_class = `IAD_OPC_NEG;
            if (f == 3'b100) group_class = `IAD_OPC_UPROD;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // opcodes followed by a ModR/M byte
   function needs_modrm;
      input [7:0] op;
      begin
         needs_modrm = (op[7:6] == 2'b00 && op[2] == 1'b0) ||
                       op[7:2] == 6'b100000 || op[7:1] == 7'b1111111 ||
                       op[7:1] == 7'b1111011;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // next-state decode
   always @* begin
      nxt_state = state_ff;
      nxt_valid = 1'b0;
      nxt_acc   = 1'b0;
      nxt_grp   = 1'b0;
      nxt_short = 1'b0;
      nxt_mem   = 1'b0;
      nxt_class = `IAD_OPC_NONE;
      cls       = first_class(byteData);
      case (state_ff)
         ST_OP: begin
            if (byteValid) begin
               if (cls != `IAD_OPC_NONE || needs_modrm(byteData)) begin
                  if (needs_modrm(byteData)) begin
                     nxt_state = ST_MODRM;
                  end else begin
                     nxt_valid = 1'b1;
                     nxt_class = cls;
                     nxt_acc   = byteData[7:6] == 2'b00 && byteData[2:1] == 2'b10;
                     nxt_short = byteData[7:4] == 4'h4;
                  end
               end
            end
         end
         ST_MODRM: begin
            if (byteValid) begin
               nxt_state = ST_OP;
               nxt_valid = 1'b1;
               nxt_mem   = byteData[7:6] != 2'b11;
               nxt_grp   = opByte_ff[7:2] == 6'b100000;
               if (opByte_ff[7:6] == 2'b00)
                  nxt_class = first_class(opByte_ff);
               else
                  nxt_class = group_class(opByte_ff, byteData[5:3]);
            end
         end
         default: nxt_state = ST_OP;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // clock cost of the unit being decoded
   assign curWord = (state_ff == ST_MODRM) ? opByte_ff[0] : byteData[0];

   iad_clock_cost u_cost (
      .opClass    (nxt_class),
      .isMem      (nxt_mem),
      .isWord     (curWord),
      .isAccImm   (nxt_acc),
      .isImmGrp   (nxt_grp),
      .isShortReg (nxt_short),
      .narrowBus  (narrowBus),
      .minClk     (costMin),
      .maxClk     (costMax)
   );

   ////////////////////////////////////////////////////////////////////
   // registers
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff       <= ST_OP;
         opByte_ff      <= 8'h00;
         opClass_ff     <= `IAD_OPC_NONE;
         wordOp_ff      <= 1'b0;
         regIsDest_ff   <= 1'b0;
         signExtImm_ff  <= 1'b0;
         memOperand_ff  <= 1'b0;
         regField_ff    <= 3'h0;
         rmField_ff     <= 3'h0;
         segSel_ff      <= 2'h0;
         segOverride_ff <= 1'b0;
         minClocks_ff   <= 6'h00;
         maxClocks_ff   <= 6'h00;
         decodeValid_ff <= 1'b0;
      end else begin
         state_ff       <= nxt_state;
         decodeValid_ff <= nxt_valid;
         if (state_ff == ST_OP && byteValid)
            opByte_ff <= byteData;
         if (nxt_valid) begin
            opClass_ff    <= nxt_class;
            minClocks_ff  <= costMin;
            maxClocks_ff  <= costMax;
            memOperand_ff <= nxt_mem;
            if (state_ff == ST_MODRM) begin
               wordOp_ff     <= opByte_ff[0];
               regIsDest_ff  <= opByte_ff[7:6] == 2'b00 && opByte_ff[1];
               signExtImm_ff <= nxt_grp && opByte_ff[1:0] == 2'b11;
               regField_ff   <= byteData[5:3];
               rmField_ff    <= byteData[2:0];
            end else begin
               wordOp_ff     <= nxt_short | byteData[0];
               regIsDest_ff  <= 1'b0;
               signExtImm_ff <= 1'b0;
               regField_ff   <= byteData[2:0];
               rmField_ff    <= 3'h0;
            end
            if (nxt_class == `IAD_OPC_PREFIX) begin
               segOverride_ff <= 1'b1;
               segSel_ff      <= byteData[4:3];
            end else begin
               segOverride_ff <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- hdl/iad_regs.vh ----
// constants for the arithmetic opcode decoder
// What this block does
// - four prefix codes select segment, 2 clocks
// - add decodes all forms, 3/4 and 3/10
// - add-with-carry forms; immediate group 4/16
// - increment/decrement group and one-byte register forms
// - subtract decodes three forms
// - subtract-with-borrow decodes three forms
// - compare forms; immediate group costs 3/10
// - negate is group field 011, 3/10
// - unpacked adjusts take 8 and 7 clocks
// - packed adjusts take 4 clocks each
// - unsigned multiply field 100 with ranged clocks
// - narrow bus adds 4 once per word memory operand, also for read-modify-write forms
`ifndef IAD_REGS_VH
`define IAD_REGS_VH
`define IAD_PFX_CODE     8'h2E
`define IAD_PFX_STACK    8'h36
`define IAD_PFX_DATA     8'h3E
`define IAD_PFX_EXTRA    8'h26
`define IAD_OP_UADJ_SUM  8'h37
`define IAD_OP_UADJ_DIF  8'h3F
`define IAD_OP_PADJ_SUM  8'h27
`define IAD_OP_PADJ_DIF  8'h2F
`define IAD_OPC_ADD      4'h0
`define IAD_OPC_ADC      4'h1
`define IAD_OPC_SUB      4'h2
`define IAD_OPC_SBB      4'h3
`define IAD_OPC_CMP      4'h4
`define IAD_OPC_INC      4'h5
`define IAD_OPC_DEC      4'h6
`define IAD_OPC_NEG      4'h7
`define IAD_OPC_UPROD    4'h8
`define IAD_OPC_UAS      4'h9
`define IAD_OPC_UAD      4'hA
`define IAD_OPC_PAS      4'hB
`define IAD_OPC_PAD      4'hC
`define IAD_OPC_PREFIX   4'hD
`define IAD_OPC_NONE     4'hF
`define IAD_CLK_PREFIX   6'h02
`define IAD_CLK_REG3     6'h03
`define IAD_CLK_ACC16    6'h04
`define IAD_CLK_IMMREG   6'h04
`define IAD_CLK_MEM10    6'h0A
`define IAD_CLK_MEM15    6'h0F
`define IAD_CLK_MEM16    6'h10
`define IAD_CLK_UAS      6'h07
`define IAD_CLK_UAD      6'h08
`define IAD_CLK_PADJ     6'h04
`define IAD_MUL_RB_MIN   6'h1A
`define IAD_MUL_RW_MIN   6'h23
`define IAD_MUL_MB_MIN   6'h20
`define IAD_MUL_MW_MIN   6'h29
`define IAD_MUL_SPAN     6'h02
`define IAD_NARROW_ADD   6'h04
`endif

// ---- tb/iad_decoder_props.sv ----
// assertions for the arithmetic opcode decoder
`timescale 1ns/1ps
`default_nettype none
module iad_decoder_props (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       narrowBus,
   input wire logic       byteValid,
   input wire logic [7:0] byteData,
   input wire logic [3:0] opClass_ff,
   input wire logic       wordOp_ff,
   input wire logic       regIsDest_ff,
   input wire logic       signExtImm_ff,
   input wire logic       segOverride_ff,
   input wire logic       memOperand_ff,
   input wire logic [2:0] regField_ff,
   input wire logic [1:0] segSel_ff,
   input wire logic [5:0] minClocks_ff,
   input wire logic [5:0] maxClocks_ff,
   input wire logic       decodeValid_ff
);
   logic       inModrm_ff;
   logic [7:0] opByte_ff;
   wire        first = byteValid & ~inModrm_ff;
   wire        second = byteValid & inModrm_ff;
   wire  [2:0] f = byteData[5:3];
   wire        mem = byteData[7:6] != 2'h3;
   wire  [5:0] ext = (narrowBus & opByte_ff[0] & mem) ? 6'h04 : 6'h00;
   wire        pairs = (byteData[7:6] == 2'h0 & ~byteData[2]) | byteData[7:2] == 6'h20
                     | byteData[7:1] == 7'h7F | byteData[7:1] == 7'h7B;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         inModrm_ff <= 1'b0;
         opByte_ff  <= 8'h00;
      end else if (byteValid) begin
         inModrm_ff <= ~inModrm_ff & pairs;
         if (~inModrm_ff) opByte_ff <= byteData;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_prefix;
      first & byteData[7:5] == 3'h1 & byteData[2:0] == 3'h6 |=> decodeValid_ff && segOverride_ff
         && opClass_ff == 4'hD && minClocks_ff == 6'h02 && segSel_ff == $past(byteData[4:3]);
   endproperty
   a_prefix: assert property (p_prefix) else $error("prefix decode wrong");
   property p_accImm;
      first & byteData[7:6] == 2'h0 & byteData[2:1] == 2'h2 & byteData[5:3] != 3'h1
         & byteData[5:3] != 3'h4 & byteData[5:3] != 3'h6 |=> decodeValid_ff && !segOverride_ff
         && minClocks_ff == 6'h03 + $past(byteData[0]);
   endproperty
   a_accImm: assert property (p_accImm) else $error("accumulator cost wrong");
   property p_carryGrp;
      second & opByte_ff[7:2] == 6'h20 & f == 3'h2 |=> opClass_ff == 4'h1
         && minClocks_ff == ($past(mem) ? 6'h10 + $past(ext) : 6'h04);
   endproperty
   a_carryGrp: assert property (p_carryGrp) else $error("carry group wrong");
   property p_cmpGrp;
      second & opByte_ff[7:2] == 6'h20 & f == 3'h7 |=> opClass_ff == 4'h4
         && minClocks_ff == ($past(mem) ? 6'h0A + $past(ext) : 6'h03);
   endproperty
   a_cmpGrp: assert property (p_cmpGrp) else $error("compare group wrong");
   property p_shortReg;
      first & byteData[7:4] == 4'h4 |=> opClass_ff == ($past(byteData[3]) ? 4'h6 : 4'h5)
         && minClocks_ff == 6'h03 && wordOp_ff && regField_ff == $past(byteData[2:0]);
   endproperty
   a_shortReg: assert property (p_shortReg) else $error("short inc/dec wrong");
   property p_adjust;
      first & byteData[7:5] == 3'h1 & byteData[2:0] == 3'h7 |=> maxClocks_ff == minClocks_ff
         && minClocks_ff == ($past(byteData[4:3]) == 2'h2 ? 6'h08 : $past(byteData[4:3])
         == 2'h3 ? 6'h07 : 6'h04);
   endproperty
   a_adjust: assert property (p_adjust) else $error("adjust cost wrong");
   property p_negate;
      second & opByte_ff[7:1] == 7'h7B & f == 3'h3 |=> opClass_ff == 4'h7
         && minClocks_ff == ($past(mem) ? 6'h0A + $past(ext) : 6'h03);
   endproperty
   a_negate: assert property (p_negate) else $error("negate wrong");
   property p_product;
      second & opByte_ff[7:1] == 7'h7B & f == 3'h4 |=> opClass_ff == 4'h8
         && maxClocks_ff == minClocks_ff + 6'h02 && minClocks_ff == ($past(mem)
         ? ($past(opByte_ff[0]) ? 6'h29 + $past(ext) : 6'h20)
         : ($past(opByte_ff[0]) ? 6'h23 : 6'h1A));
   endproperty
   a_product: assert property (p_product) else $error("multiply cost wrong");
   property p_bits;
      second & opByte_ff[7:6] == 2'h0 |=> regIsDest_ff == $past(opByte_ff[1]) && !signExtImm_ff
         && wordOp_ff == $past(opByte_ff[0]) && memOperand_ff == $past(mem);
   endproperty
   a_bits: assert property (p_bits) else $error("operand bits wrong");
   property p_signExt;
      second & opByte_ff[7:2] == 6'h20 |=> decodeValid_ff
         && signExtImm_ff == $past(opByte_ff[1] & opByte_ff[0]);
   endproperty
   a_signExt: assert property (p_signExt) else $error("sign extend bit wrong");
   c_prefix: cover property (decodeValid_ff && opClass_ff == 4'hD);
   c_product: cover property (decodeValid_ff && opClass_ff == 4'h8);
   c_narrow: cover property (decodeValid_ff && memOperand_ff && wordOp_ff && narrowBus);
endmodule
bind iad_opcode_decoder iad_decoder_props i_props (.clk(clk), .rst(rst),
   .narrowBus(narrowBus), .byteValid(byteValid), .byteData(byteData),
   .opClass_ff(opClass_ff), .wordOp_ff(wordOp_ff), .regIsDest_ff(regIsDest_ff),
   .signExtImm_ff(signExtImm_ff), .segOverride_ff(segOverride_ff),
   .memOperand_ff(memOperand_ff), .regField_ff(regField_ff), .segSel_ff(segSel_ff),
   .minClocks_ff(minClocks_ff), .maxClocks_ff(maxClocks_ff), .decodeValid_ff(decodeValid_ff));
`default_nettype wire

// ---- tb/iad_queue_model.sv ----
// prefetch queue model feeding instruction bytes with random gaps
`timescale 1ns/1ps
`default_nettype none
module iad_queue_model (
   input  wire logic       clk,
   input  wire logic       byteReady,
   output var  logic       byteValid = 1'b0,
   output var  logic [7:0] byteData = 8'h00,
   output var  logic       narrowBus = 1'b0
);
   logic [8:0] q[$];
   always @(negedge clk) begin
      if (byteReady && q.size() != 0 && $urandom_range(3) != 0) begin
         {narrowBus, byteData} <= q.pop_front();
         byteValid <= 1'b1;
      end else begin
         byteValid <= 1'b0;
         byteData  <= ~byteData;
      end
   end
endmodule
`default_nettype wire

// ---- tb/test_integer_arith_opcode_decoder.sv ----
// self-checking bench for the arithmetic opcode decoder
`timescale 1ns/1ps
`default_nettype none
module test_integer_arith_opcode_decoder;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   wire         byteValid, narrowBus, byteReady, decodeValid, wordOp, memOp;
   wire  [7:0]  byteData;
   wire  [3:0]  opClass;
   wire  [2:0]  regField, rmField;
   wire  [5:0]  minClk, maxClk;
   logic [24:0] notes[$];
   logic [24:0] n;
   logic [7:0]  op;
   int          failures = 0;
   int          checksDone = 0;
   int          cycles = 0;
   int          i;
   logic [7:0]  bases[8] = '{8'h00, 8'h10, 8'h28, 8'h18, 8'h38, 8'h80, 8'hFE, 8'hF6};
   always #4 clk = ~clk;
   iad_queue_model i_queue (.clk(clk), .byteReady(byteReady), .byteValid(byteValid),
      .byteData(byteData), .narrowBus(narrowBus));
   iad_opcode_decoder i_dut (.clk(clk), .rst(rst), .narrowBus(narrowBus),
      .byteValid(byteValid), .byteData(byteData), .byteReady(byteReady),
      .opClass_ff(opClass), .wordOp_ff(wordOp), .regIsDest_ff(), .signExtImm_ff(),
      .memOperand_ff(memOp), .regField_ff(regField), .rmField_ff(rmField), .segSel_ff(),
      .segOverride_ff(), .minClocks_ff(minClk), .maxClocks_ff(maxClk),
      .decodeValid_ff(decodeValid));
   function automatic logic [3:0] cls(input logic [2:0] f);
      case (f)
         3'h0: cls = 4'h0;
         3'h2: cls = 4'h1;
         3'h5: cls = 4'h2;
         3'h3: cls = 4'h3;
         3'h7: cls = 4'h4;
         default: cls = 4'hF;
      endcase
   endfunction
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
      checksDone++;
      if (seen !== want) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic one(input logic [7:0] b, input logic [3:0] k, input logic [5:0] c);
      i_queue.q.push_back({1'($urandom_range(1)), b});
      notes.push_back({k, c, c, 9'h000});
   endtask
   task automatic two(input logic [7:0] b, input logic [7:0] m);
      logic       nb;
      logic       mem;
      logic [2:0] f;
      logic [3:0] k;
      logic [5:0] c;
      logic [5:0] x;
      nb = 1'($urandom_range(1));
      mem = m[7:6] != 2'h3;
      f = m[5:3];
      x = (nb & b[0] & mem) ? 6'h04 : 6'h00;
      k = cls(f);
      c = mem ? 6'h0A + x : 6'h03;
      if (b[7:6] == 2'h0) k = cls(b[5:3]);
      else if (b[7:2] == 6'h20 && f != 3'h7) c = mem ? 6'h10 + x : 6'h04;
      else if (b[7:1] == 7'h7F) begin
         k = f == 3'h0 ? 4'h5 : (f == 3'h1 ? 4'h6 : 4'hF);
         c = mem ? 6'h0F + x : 6'h03;
      end else if (b[7:1] == 7'h7B) begin
         k = f == 3'h3 ? 4'h7 : (f == 3'h4 ? 4'h8 : 4'hF);
         if (f == 3'h4) c = mem ? (b[0] ? 6'h29 + x : 6'h20) : (b[0] ? 6'h23 : 6'h1A);
      end
      if (k == 4'hF) c = 6'h00;
      i_queue.q.push_back({nb, b});
      i_queue.q.push_back({nb, m});
      notes.push_back({k, c, k == 4'h8 ? c + 6'h02 : c, k != 4'hF, b[0], mem, m[5:0]});
   endtask
   always @(negedge clk) begin
      if (decodeValid === 1'b1) begin
         if (notes.size() == 0) check("spurious pulse", 16'h0001, 16'h0000);
         else begin
            n = notes.pop_front();
            check("class and cost", {opClass, minClk, maxClk}, n[24:9]);
            if (n[8]) check("operand", {wordOp, memOp, regField, rmField}, n[7:0]);
         end
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         report_and_stop;
      end
   end
   initial begin
      void'($urandom(90447));
      repeat (12) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      for (i = 0; i < 4; i++) one(8'h26 + 8'(i * 8), 4'hD, 6'h02);
      one(8'h37, 4'hA, 6'h08);
      one(8'h3F, 4'h9, 6'h07);
      one(8'h27, 4'hC, 6'h04);
      one(8'h2F, 4'hB, 6'h04);
      i_queue.q.push_back(9'h0F4);
      for (i = 0; i < 16; i++) one(8'h40 + 8'(i), i < 8 ? 4'h5 : 4'h6, 6'h03);
      for (i = 0; i < 10; i++) begin
         op = bases[i / 2] | 8'h04 | 8'(i % 2);
         one(op, cls(op[5:3]), 6'h03 + 6'(i % 2));
      end
      for (i = 0; i < 400; i++) begin
         op = bases[$urandom_range(7)];
         op = op | 8'(op[7:6] == 2'h3 ? $urandom_range(1) : $urandom_range(3));
         two(op, 8'($urandom_range(255)));
      end
      for (i = 0; i < 4000 && notes.size() != 0; i++) @(posedge clk);
      repeat (4) @(posedge clk);
      check("pending decodes", 16'(notes.size()), 16'h0000);
      report_and_stop;
   end
endmodule
`default_nettype wire
